// File: mcc_consts.svh
// constants for the output cell array: sizes, register map, reset values
// Behaviour
// - registers share one clock and enable pin
// - each cell registered or I/O in registered mode
// - any mix of registered and I/O cells
// - registered sums eight terms, I/O seven
// - dedicated input/output are restricted I/O cells
// - registers capture on shared clock rising edge
// - simple mode: input or always-driven output
// - simple outputs sum at most eight terms
// - polarity bit: clear active low, set high
// - simple mode: clock/enable pins are data
// - simple mode: centre cells output only
// - simple output selected by 1,0,direction 0
// - simple mode: centre cells have no own feedback
// - direction 1 in simple mode: input, driver off
// - two global bits, per-cell polarity and direction
// - registered mode: clock/enable pins not data
// - registers clear low at power-up
`ifndef MCC_CONSTS_SVH
`define MCC_CONSTS_SVH

// default sizes
`define MCC_NUM_CELLS 8
`define MCC_NUM_INPUTS 8
`define MCC_NUM_TERMS 8
`define MCC_MAX_CELLS 8
`define MCC_MAX_INPUTS 8
`define MCC_MAX_WORDS 64

// register port
`define MCC_ADDR_W 10
`define MCC_DATA_W 32
`define MCC_OFS_CTRL 10'h000
`define MCC_OFS_POLARITY 10'h004
`define MCC_OFS_DIRECTION 10'h008
`define MCC_OFS_STATUS 10'h00C
`define MCC_OFS_PINS 10'h010
`define MCC_OFS_TDIS_LO 10'h014
`define MCC_OFS_TDIS_HI 10'h018
`define MCC_TERM_SEL_MSB 9
`define MCC_TERM_SEL_LSB 8
`define MCC_TERM_SEL 2'h1
`define MCC_TERM_IDX_MSB 7
`define MCC_TERM_IDX_LSB 2
`define MCC_TERM_IDX_W 6

// fields
`define MCC_CTRL_REGSEL_BIT 0
`define MCC_CTRL_ARCH_BIT 1
`define MCC_STAT_Q_LSB 0
`define MCC_STAT_OFF_BIT 8
`define MCC_STAT_REG_BIT 9
`define MCC_STAT_SIMPLE_BIT 10
`define MCC_PINS_DATA_LSB 0
`define MCC_PINS_PAD_LSB 8
`define MCC_PINS_CLK_BIT 16
`define MCC_PINS_OE_BIT 17
`define MCC_TDIS_W 64
`define MCC_TDIS_HALF 32

// reset values
`define MCC_CTRL_REGSEL_RST 1'b1
`define MCC_CTRL_ARCH_RST 1'b0
`define MCC_POL_RST_BIT 1'b1
`define MCC_DIR_RST_BIT 1'b1
`define MCC_TERM_RST_BIT 1'b1
`define MCC_TDIS_RST 64'h0000000000000000
`define MCC_Q_RST 1'b0
`define MCC_CLKPIN_RST 1'b1

`endif

// File: mcc_pkg.sv
// types shared by the output cell array
`default_nettype none
`include "mcc_consts.svh"
package mcc_pkg;

  typedef enum logic [2:0] {
    MCC_MODE_REG = 3'h1,
    MCC_MODE_SIMPLE = 3'h2,
    MCC_MODE_OFF = 3'h4
  } mcc_mode_t;

  typedef struct packed {
    logic polarity;
    logic direction;
  } mcc_cell_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
  } mcc_pad_t;

  typedef struct packed {
    logic [`MCC_ADDR_W-1:0] addr;
    logic [`MCC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } mcc_bus_req_t;

endpackage : mcc_pkg
`default_nettype wire

// File: mcc_cell.sv
// one output logic cell: register, polarity and driver control
`timescale 1ns/10ps
`default_nettype none
`include "mcc_consts.svh"
module mcc_cell #(
  parameter int NUM_TERMS = `MCC_NUM_TERMS,
  parameter bit CENTER = 1'b0
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // configuration
  input wire mcc_pkg::mcc_mode_t mode_i,
  input wire mcc_pkg::mcc_cell_cfg_t cfg_i,
  // array and pins
  input wire logic [NUM_TERMS-1:0] terms_i,
  input wire logic clk_rise_i,
  input wire logic oe_n_i,
  input wire logic pad_in_i,
  // results
  output logic q_o,
  output logic fb_o,
  output mcc_pkg::mcc_pad_t drive_o
);

  logic q;
  logic next_q;
  mcc_pkg::mcc_pad_t drive;
  mcc_pkg::mcc_pad_t next_drive;
  logic sum_all;
  logic sum_io;

  always_comb begin
    sum_all = |terms_i;
    sum_io = |terms_i[NUM_TERMS-1:1];
    next_q = q;
    next_drive = '0;
    case (mode_i)
      mcc_pkg::MCC_MODE_REG: begin
        if (!cfg_i.direction) begin
          if (clk_rise_i) begin
            next_q = sum_all ^ cfg_i.polarity;
          end
          // pin shows inverted q, so a cleared register reads high
          next_drive.out = ~next_q;
          next_drive.oe = ~oe_n_i;
        end else begin
          // term 0 is the private enable; input/output use is a subset
          next_drive.out = cfg_i.polarity ? sum_io : ~sum_io;
          next_drive.oe = terms_i[0];
        end
      end
      mcc_pkg::MCC_MODE_SIMPLE: begin
        if (!cfg_i.direction || CENTER) begin
          next_drive.out = cfg_i.polarity ? sum_all : ~sum_all;
          next_drive.oe = 1'b1;
        end else begin
          next_drive.oe = 1'b0;
        end
      end
      default: begin
        next_drive = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= `MCC_Q_RST;
      drive <= '0;
    end else begin
      q <= next_q;
      drive <= next_drive;
    end
  end

  // registered cells feed back q even while the driver is off
  assign fb_o = (mode_i == mcc_pkg::MCC_MODE_REG && !cfg_i.direction) ? q : pad_in_i;
  assign q_o = q;
  assign drive_o = drive;

endmodule : mcc_cell
`default_nettype wire

// File: mcc_top.sv
// configurable output cell array with its product-term array and registers
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "mcc_consts.svh"
module mcc_top #(
  parameter int NUM_CELLS = `MCC_NUM_CELLS,
  parameter int NUM_INPUTS = `MCC_NUM_INPUTS,
  parameter int NUM_TERMS = `MCC_NUM_TERMS
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // register port
  input wire logic [`MCC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`MCC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`MCC_DATA_W-1:0] reg_rdata_o,
  // device pins
  input wire logic [NUM_INPUTS-1:0] data_in_i,
  input wire logic shared_clk_pin_i,
  input wire logic shared_oe_n_pin_i,
  input wire logic [NUM_CELLS-1:0] pad_in_i,
  output logic [NUM_CELLS-1:0] pad_out_o,
  output logic [NUM_CELLS-1:0] pad_oe_o,
  // cell register state
  output logic [NUM_CELLS-1:0] cell_state_o
);

  localparam int NUM_COLS = NUM_INPUTS + NUM_CELLS;
  localparam int MASK_W = 2 * NUM_COLS;
  localparam int NUM_WORDS = NUM_CELLS * NUM_TERMS;
  localparam int HALF = NUM_CELLS / 2;

  generate
    if (NUM_CELLS < 4 || NUM_CELLS > `MCC_MAX_CELLS || (NUM_CELLS % 2) != 0) begin : g_bad_cells
      $error("cell count must be even, 4 to 8");
    end
    if (NUM_INPUTS < 1 || NUM_INPUTS > `MCC_MAX_INPUTS) begin : g_bad_inputs
      $error("input count must be 1 to 8");
    end
    if (NUM_TERMS < 2 || NUM_WORDS > `MCC_MAX_WORDS) begin : g_bad_terms
      $error("need two or more terms and at most 64 term words");
    end
    // both literals of every column must fit one data word
    if (MASK_W > `MCC_DATA_W) begin : g_bad_mask
      $error("term mask wider than the data word");
    end
  endgenerate

  // global mode from the two global bits
  function automatic mcc_pkg::mcc_mode_t mode_of(input logic regsel, input logic arch);
    mcc_pkg::mcc_mode_t m;
    case ({regsel, arch})
      2'h1: m = mcc_pkg::MCC_MODE_REG;
      2'h2: m = mcc_pkg::MCC_MODE_SIMPLE;
      // the third global mode is not built here: every driver stays off
      default: m = mcc_pkg::MCC_MODE_OFF;
    endcase
    return m;
  endfunction : mode_of

  function automatic logic reg_hit(input logic [`MCC_ADDR_W-1:0] addr,
                                   input logic [`MCC_ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction : reg_hit

  function automatic logic term_hit(input logic [`MCC_ADDR_W-1:0] addr);
    logic [`MCC_TERM_IDX_W-1:0] idx;
    idx = addr[`MCC_TERM_IDX_MSB:`MCC_TERM_IDX_LSB];
    return (addr[`MCC_TERM_SEL_MSB:`MCC_TERM_SEL_LSB] == `MCC_TERM_SEL) &&
           (int'(idx) < NUM_WORDS);
  endfunction : term_hit

  // one product term: even mask bit ties a true column, odd one the complement
  function automatic logic term_eval(input logic [MASK_W-1:0] mask,
                                     input logic [NUM_COLS-1:0] cols);
    logic hit;
    hit = 1'b1;
    for (int k = 0; k < NUM_COLS; k++) begin
      if (mask[2*k] && !cols[k]) begin
        hit = 1'b0;
      end
      if (mask[2*k+1] && cols[k]) begin
        hit = 1'b0;
      end
    end
    return hit;
  endfunction : term_eval

  // strobe and its qualifiers travel as one bundle
  mcc_pkg::mcc_bus_req_t req;
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // configuration state
  logic ctrl_regsel;
  logic ctrl_arch;
  logic [NUM_CELLS-1:0] polarity;
  logic [NUM_CELLS-1:0] direction;
  logic [`MCC_TDIS_W-1:0] term_disable_fuse;
  // flip-flop storage, rewritable at any time
  logic [MASK_W-1:0] term_mem [NUM_WORDS];
  logic next_ctrl_regsel;
  logic next_ctrl_arch;
  logic [NUM_CELLS-1:0] next_polarity;
  logic [NUM_CELLS-1:0] next_direction;
  logic [`MCC_TDIS_W-1:0] next_term_disable_fuse;
  logic [MASK_W-1:0] next_term_mem [NUM_WORDS];
  logic [`MCC_TERM_IDX_W-1:0] wr_idx;

  always_comb begin
    next_ctrl_regsel = ctrl_regsel;
    next_ctrl_arch = ctrl_arch;
    next_polarity = polarity;
    next_direction = direction;
    next_term_disable_fuse = term_disable_fuse;
    next_term_mem = term_mem;
    wr_idx = req.addr[`MCC_TERM_IDX_MSB:`MCC_TERM_IDX_LSB];
    // unmapped offsets fall through untouched
    if (req.wr) begin
      if (reg_hit(req.addr, `MCC_OFS_CTRL)) begin
        next_ctrl_regsel = req.wdata[`MCC_CTRL_REGSEL_BIT];
        next_ctrl_arch = req.wdata[`MCC_CTRL_ARCH_BIT];
      end
      if (reg_hit(req.addr, `MCC_OFS_POLARITY)) begin
        next_polarity = req.wdata[NUM_CELLS-1:0];
      end
      if (reg_hit(req.addr, `MCC_OFS_DIRECTION)) begin
        next_direction = req.wdata[NUM_CELLS-1:0];
      end
      if (reg_hit(req.addr, `MCC_OFS_TDIS_LO)) begin
        next_term_disable_fuse[`MCC_TDIS_HALF-1:0] = req.wdata;
      end
      if (reg_hit(req.addr, `MCC_OFS_TDIS_HI)) begin
        next_term_disable_fuse[`MCC_TDIS_W-1:`MCC_TDIS_HALF] = req.wdata;
      end
      if (term_hit(req.addr)) begin
        next_term_mem[wr_idx] = req.wdata[MASK_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_regsel <= `MCC_CTRL_REGSEL_RST;
      ctrl_arch <= `MCC_CTRL_ARCH_RST;
      polarity <= {NUM_CELLS{`MCC_POL_RST_BIT}};
      direction <= {NUM_CELLS{`MCC_DIR_RST_BIT}};
      term_disable_fuse <= `MCC_TDIS_RST;
      for (int i = 0; i < NUM_WORDS; i++) begin
        // every tie made: true and complement together keep each term low
        term_mem[i] <= {MASK_W{`MCC_TERM_RST_BIT}};
      end
    end else begin
      ctrl_regsel <= next_ctrl_regsel;
      ctrl_arch <= next_ctrl_arch;
      polarity <= next_polarity;
      direction <= next_direction;
      term_disable_fuse <= next_term_disable_fuse;
      term_mem <= next_term_mem;
    end
  end

  mcc_pkg::mcc_mode_t mode;
  // a mode change reaches the pads one clock later
  assign mode = mode_of(ctrl_regsel, ctrl_arch);

  // shared clock pin edge; inputs are synchronous, so no synchroniser
  logic clkpin_q;
  logic next_clkpin_q;
  logic clk_rise;

  always_comb begin
    next_clkpin_q = shared_clk_pin_i;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // held high so a pin already high at release is no edge
      clkpin_q <= `MCC_CLKPIN_RST;
    end else begin
      clkpin_q <= next_clkpin_q;
    end
  end

  // pin must stay high across a system clock edge to count
  assign clk_rise = (mode == mcc_pkg::MCC_MODE_REG) && shared_clk_pin_i && !clkpin_q;

  // array columns: data inputs low, one feedback column per cell above
  logic [NUM_CELLS-1:0] cell_fb;
  logic [NUM_CELLS-1:0] fb_col;
  logic [NUM_COLS-1:0] cols;

  genvar j;
  generate
    for (j = 0; j < NUM_CELLS; j++) begin : g_col
      logic simple_src;
      if (j == 0) begin : g_edge_lo
        assign simple_src = shared_clk_pin_i;
      end else if (j == NUM_CELLS - 1) begin : g_edge_hi
        assign simple_src = shared_oe_n_pin_i;
      end else if (j < HALF) begin : g_lower
        assign simple_src = pad_in_i[j-1];
      end else begin : g_upper
        assign simple_src = pad_in_i[j+1];
      end
      // clock and enable pins never reach the array in registered mode
      assign fb_col[j] = (mode == mcc_pkg::MCC_MODE_REG) ? cell_fb[j] :
                         (mode == mcc_pkg::MCC_MODE_SIMPLE) ? simple_src : 1'b0;
    end
  endgenerate

  assign cols = {fb_col, data_in_i};

  // product terms and cells
  mcc_pkg::mcc_pad_t [NUM_CELLS-1:0] drive;
  logic [NUM_CELLS-1:0] cell_q;

  genvar c;
  genvar t;
  generate
    for (c = 0; c < NUM_CELLS; c++) begin : g_cell
      logic [NUM_TERMS-1:0] terms;
      mcc_pkg::mcc_cell_cfg_t cfg;
      for (t = 0; t < NUM_TERMS; t++) begin : g_term
        // a disabled term drops out of the sum
        assign terms[t] = term_eval(term_mem[c*NUM_TERMS+t], cols) &&
                          !term_disable_fuse[c*NUM_TERMS+t];
      end
      // polarity and direction travel together to each cell
      assign cfg = '{polarity: polarity[c], direction: direction[c]};
      mcc_cell #(
        .NUM_TERMS(NUM_TERMS),
        .CENTER((c == HALF - 1) || (c == HALF))
      ) u_cell (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .mode_i(mode),
        .cfg_i(cfg),
        .terms_i(terms),
        .clk_rise_i(clk_rise),
        .oe_n_i(shared_oe_n_pin_i),
        .pad_in_i(pad_in_i[c]),
        .q_o(cell_q[c]),
        .fb_o(cell_fb[c]),
        .drive_o(drive[c])
      );
      assign pad_out_o[c] = drive[c].out;
      assign pad_oe_o[c] = drive[c].oe;
    end
  endgenerate

  assign cell_state_o = cell_q;

  // read path: data only in the cycle after the strobe, zero elsewhere
  logic [`MCC_DATA_W-1:0] rdata;
  logic [`MCC_DATA_W-1:0] next_rdata;
  logic [`MCC_TERM_IDX_W-1:0] rd_idx;

  always_comb begin
    next_rdata = '0;
    rd_idx = req.addr[`MCC_TERM_IDX_MSB:`MCC_TERM_IDX_LSB];
    if (req.rd) begin
      if (reg_hit(req.addr, `MCC_OFS_CTRL)) begin
        next_rdata[`MCC_CTRL_REGSEL_BIT] = ctrl_regsel;
        next_rdata[`MCC_CTRL_ARCH_BIT] = ctrl_arch;
      end else if (reg_hit(req.addr, `MCC_OFS_POLARITY)) begin
        next_rdata[NUM_CELLS-1:0] = polarity;
      end else if (reg_hit(req.addr, `MCC_OFS_DIRECTION)) begin
        next_rdata[NUM_CELLS-1:0] = direction;
      end else if (reg_hit(req.addr, `MCC_OFS_STATUS)) begin
        next_rdata[`MCC_STAT_Q_LSB +: NUM_CELLS] = cell_q;
        next_rdata[`MCC_STAT_OFF_BIT] = (mode == mcc_pkg::MCC_MODE_OFF);
        next_rdata[`MCC_STAT_REG_BIT] = (mode == mcc_pkg::MCC_MODE_REG);
        next_rdata[`MCC_STAT_SIMPLE_BIT] = (mode == mcc_pkg::MCC_MODE_SIMPLE);
      end else if (reg_hit(req.addr, `MCC_OFS_PINS)) begin
        next_rdata[`MCC_PINS_DATA_LSB +: NUM_INPUTS] = data_in_i;
        next_rdata[`MCC_PINS_PAD_LSB +: NUM_CELLS] = pad_in_i;
        next_rdata[`MCC_PINS_CLK_BIT] = shared_clk_pin_i;
        next_rdata[`MCC_PINS_OE_BIT] = shared_oe_n_pin_i;
      end else if (reg_hit(req.addr, `MCC_OFS_TDIS_LO)) begin
        next_rdata = term_disable_fuse[`MCC_TDIS_HALF-1:0];
      end else if (reg_hit(req.addr, `MCC_OFS_TDIS_HI)) begin
        next_rdata = term_disable_fuse[`MCC_TDIS_W-1:`MCC_TDIS_HALF];
      end else if (term_hit(req.addr)) begin
        next_rdata[MASK_W-1:0] = term_mem[rd_idx];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;

endmodule : mcc_top
`default_nettype wire

// File: mcc_board.sv
// board model around the cell pads: pull-ups and an optional external driver
`timescale 1ns/10ps
`default_nettype none
module mcc_board #(
  parameter int NUM_CELLS = 8
) (
  // from the device
  input wire logic [NUM_CELLS-1:0] pad_out_i,
  input wire logic [NUM_CELLS-1:0] pad_oe_i,
  // external drivers on the board
  input wire logic [NUM_CELLS-1:0] ext_val_i,
  input wire logic [NUM_CELLS-1:0] ext_en_i,
  // resolved pad levels
  output logic [NUM_CELLS-1:0] pad_o
);
  // released pads float high through the pad pull-ups unless an external driver is on, never hold a stale level
  always_comb begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      pad_o[i] = pad_oe_i[i] ? pad_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
    end
  end
endmodule : mcc_board
`default_nettype wire

// File: mcc_top_props.sv
// assertion checker for the output cell array, bound to mcc_top
`timescale 1ns/10ps
`default_nettype none
`include "mcc_consts.svh"
module mcc_top_props #(
  parameter int NUM_CELLS = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // register port
  input wire logic [`MCC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`MCC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`MCC_DATA_W-1:0] reg_rdata_o,
  // pins
  input wire logic shared_clk_pin_i,
  input wire logic shared_oe_n_pin_i,
  input wire logic [NUM_CELLS-1:0] pad_out_o,
  input wire logic [NUM_CELLS-1:0] pad_oe_o,
  input wire logic [NUM_CELLS-1:0] cell_state_o
);
  localparam logic [NUM_CELLS-1:0] CENTRE = NUM_CELLS'(3) << (NUM_CELLS / 2 - 1);
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  logic [NUM_CELLS-1:0] dir;
  logic [NUM_CELLS-1:0] next_dir;
  logic [1:0] quiet;
  logic [1:0] next_quiet;
  logic reg_m;
  logic simple_m;
  // shadow of the config; outputs lag a write, so checks wait until quiet
  always_comb begin
    next_ctrl = ctrl;
    next_dir = dir;
    next_quiet = (quiet == 2'h3) ? quiet : quiet + 2'h1;
    if (reg_wr_i) begin
      next_quiet = 2'h0;
      if (reg_addr_i == `MCC_OFS_CTRL) next_ctrl = reg_wdata_i[1:0];
      if (reg_addr_i == `MCC_OFS_DIRECTION) next_dir = reg_wdata_i[NUM_CELLS-1:0];
    end
  end
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= {`MCC_CTRL_ARCH_RST, `MCC_CTRL_REGSEL_RST};
      dir <= {NUM_CELLS{`MCC_DIR_RST_BIT}};
      quiet <= 2'h0;
    end else begin
      ctrl <= next_ctrl;
      dir <= next_dir;
      quiet <= next_quiet;
    end
  end
  assign reg_m = (ctrl == 2'h2);
  assign simple_m = (ctrl == 2'h1);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  AST_RESET_CLEAR: assert property ($rose(rstn_i) |-> cell_state_o == '0)
    else $error("cell state not cleared by reset");
  AST_LOAD_ON_RISE: assert property ($changed(cell_state_o) |->
    $past(shared_clk_pin_i) && !$past(shared_clk_pin_i, 2) && $past(reg_m))
    else $error("cell state changed without a clock pin rise in registered mode");
  AST_SIMPLE_DRIVE: assert property (simple_m && quiet[1] |-> pad_oe_o == (~dir | CENTRE))
    else $error("simple mode driver enables wrong");
  AST_OFF_DRIVERS: assert property (!simple_m && !reg_m && quiet[1] |-> pad_oe_o == '0)
    else $error("unsupported mode drives a pad");
  AST_REG_OE: assert property (reg_m && quiet[1] |->
    (pad_oe_o & ~dir) == ($past(shared_oe_n_pin_i) ? '0 : ~dir))
    else $error("registered outputs not gated by the shared enable pin");
  AST_REG_OUT: assert property (reg_m && quiet[1] && !$past(shared_oe_n_pin_i) |->
    (pad_out_o & ~dir) == (~cell_state_o & ~dir))
    else $error("registered pad does not show the inverted state");
  AST_OE_KEEPS_STATE: assert property ($rose(shared_oe_n_pin_i)
    && !$rose(shared_clk_pin_i) |=> $stable(cell_state_o))
    else $error("output disable disturbed the cell state");
  AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside the read answer cycle");
  COV_LOAD: cover property (reg_m && $rose(shared_clk_pin_i));
  COV_SIMPLE_OUT: cover property (simple_m && quiet[1] && (pad_oe_o & ~CENTRE) != '0);
  COV_OE_OFF: cover property (reg_m && shared_oe_n_pin_i);
endmodule : mcc_top_props
bind mcc_top mcc_top_props #(.NUM_CELLS(NUM_CELLS)) u_props (
  .clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .shared_clk_pin_i(shared_clk_pin_i),
  .shared_oe_n_pin_i(shared_oe_n_pin_i),
  .pad_out_o(pad_out_o),
  .pad_oe_o(pad_oe_o),
  .cell_state_o(cell_state_o)
);
`default_nettype wire

// File: mcc_top_tb_top.sv
// self-checking bench for the output cell array
`timescale 1ns/10ps
`default_nettype none
`include "mcc_consts.svh"
module mcc_top_tb_top;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [`MCC_ADDR_W-1:0] addr = '0;
  logic [`MCC_DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [`MCC_DATA_W-1:0] rdata;
  logic [7:0] din = '0;
  logic cpin = 1'b0;
  logic oen = 1'b0;
  logic [7:0] ext_val = '0;
  logic [7:0] ext_en = '0;
  logic [7:0] pad_in;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic [7:0] state;
  logic q = 1'b0;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  mcc_top dut (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .reg_addr_i(addr),
    .reg_wdata_i(wdata),
    .reg_wr_i(wr),
    .reg_rd_i(rd),
    .reg_rdata_o(rdata),
    .data_in_i(din),
    .shared_clk_pin_i(cpin),
    .shared_oe_n_pin_i(oen),
    .pad_in_i(pad_in),
    .pad_out_o(pad_out),
    .pad_oe_o(pad_oe),
    .cell_state_o(state)
  );
  mcc_board u_board (
    .pad_out_i(pad_out),
    .pad_oe_i(pad_oe),
    .ext_val_i(ext_val),
    .ext_en_i(ext_en),
    .pad_o(pad_in)
  );
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // a few hundred cycles are expected; the ceiling leaves wide margin
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [`MCC_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [`MCC_ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_reg
  task automatic term(input int c, input int t, input logic [31:0] m);
    wr_reg(10'h100 + 10'(4 * (c * 8 + t)), m);
  endtask : term
  // outputs are registered: allow the sampling edge plus one before looking
  task automatic pins(input logic [7:0] d, input logic c, input logic o);
    @(posedge clk_sys_i);
    din <= d;
    cpin <= c;
    oen <= o;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : pins
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    pins(8'h00, 1'b0, 1'b0);
    check(32'({state, pad_oe, pad_out}), 32'h001800);
    rd_reg(`MCC_OFS_CTRL, 32'h1);
    rd_reg(`MCC_OFS_POLARITY, 32'hFF);
    rd_reg(`MCC_OFS_DIRECTION, 32'hFF);
    rd_reg(10'h020, 32'h0);
    term(0, 0, 32'h1);
    term(0, 7, 32'h4);
    term(1, 0, 32'h0001_0000);
    term(1, 1, 32'h4000_0000);
    term(2, 0, 32'h0004_0000);
    wr_reg(`MCC_OFS_DIRECTION, 32'hF8);
    for (int i = 0; i < 8; i++) begin
      wr_reg(`MCC_OFS_POLARITY, i[2] ? 32'hFF : 32'hFE);
      pins({6'h0, i[1:0]}, 1'b0, 1'b0);
      check(32'(pad_out[0]), 32'((|i[1:0]) == i[2]));
    end
    check(32'(pad_oe), 32'h1F);
    pins(8'h00, 1'b1, 1'b0);
    check(32'({state[1], pad_out[1]}), 32'h1);
    pins(8'h00, 1'b0, 1'b1);
    check(32'(pad_out[1]), 32'h1);
    pins(8'h00, 1'b0, 1'b0);
    check(32'(pad_out[1]), 32'h0);
    wr_reg(`MCC_OFS_DIRECTION, 32'hF9);
    ext_en <= 8'h01;
    for (int v = 0; v < 2; v++) begin
      ext_val <= 8'(v);
      pins(8'h00, 1'b0, 1'b0);
      check(32'({pad_oe[0], pad_out[2]}), 32'(v));
    end
    ext_en <= 8'h00;
    wr_reg(`MCC_OFS_CTRL, 32'h3);
    pins(8'h00, 1'b0, 1'b0);
    check(32'(pad_oe), 32'h0);
    rd_reg(`MCC_OFS_STATUS, 32'h0000_0100);
    term(1, 0, 32'hFFFF_FFFF);
    term(2, 0, 32'hFFFF_FFFF);
    wr_reg(`MCC_OFS_CTRL, 32'h2);
    wr_reg(`MCC_OFS_DIRECTION, 32'hFE);
    pins(8'h00, 1'b0, 1'b0);
    check(32'({pad_oe, pad_out[0], state[0]}), 32'h006);
    for (int i = 0; i < 8; i++) begin
      wr_reg(`MCC_OFS_POLARITY, i[2] ? 32'hFF : 32'hFE);
      pins({6'h0, i[1:0]}, 1'b0, 1'b0);
      check(32'(state[0]), 32'(q));
      pins({6'h0, i[1:0]}, 1'b1, 1'b0);
      q = (|i[1:0]) ^ i[2];
      check(32'({state[0], pad_out[0]}), 32'({q, ~q}));
    end
    pins(8'h00, 1'b0, 1'b1);
    check(32'({pad_oe[0], state[0]}), 32'h0);
    pins(8'h00, 1'b1, 1'b1);
    check(32'(state[0]), 32'h1);
    pins(8'h00, 1'b0, 1'b0);
    check(32'({pad_oe[0], pad_out[0]}), 32'h2);
    check(32'(pad_out[1]), 32'h1);
    term(5, 0, 32'h0);
    term(5, 1, 32'h10);
    term(5, 7, 32'h40);
    for (int i = 0; i < 3; i++) begin
      pins(8'(4 << i), 1'b0, 1'b0);
      check(32'({pad_oe[5], pad_out[5]}), i < 2 ? 32'h3 : 32'h2);
    end
    wr_reg(`MCC_OFS_TDIS_HI, 32'h0000_0100);
    rd_reg(`MCC_OFS_TDIS_HI, 32'h0000_0100);
    pins(8'h00, 1'b0, 1'b0);
    check(32'(pad_oe[5]), 32'h0);
    wr_reg(`MCC_OFS_TDIS_HI, 32'h0);
    term(5, 0, 32'hFFFF_FFFF);
    pins(8'h00, 1'b0, 1'b0);
    check(32'({pad_oe[5], pad_in[5]}), 32'h1);
    wr_reg(`MCC_OFS_DIRECTION, 32'h0);
    pins(8'h00, 1'b1, 1'b0);
    check(32'({state, pad_oe, pad_out}), 32'hFFFF00);
    rd_reg(`MCC_OFS_STATUS, 32'h0000_02FF);
    rd_reg(`MCC_OFS_PINS, 32'h0001_0000);
    pins(8'h00, 1'b0, 1'b0);
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check(32'({state, pad_oe}), 32'h0);
    @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd_reg(`MCC_OFS_CTRL, 32'h1);
    print_verdict();
  end
endmodule : mcc_top_tb_top
`default_nettype wire
